/* src/fault_protection_defines.vh */
// Register map, field positions, reset values and timing counts
`ifndef FAULT_PROTECTION_DEFINES_VH
`define FAULT_PROTECTION_DEFINES_VH

`define OFS_STATUS         4'h0
`define OFS_CONFIG         4'h4
`define OFS_STATE          4'h8

`define BIT_SUPPLY_LOW     0
`define BIT_SUPPLY_HIGH    1
`define BIT_OVERCURRENT    2
`define BIT_PUMP_LOW       3
`define BIT_PUMP_SHORT     4
`define BIT_OVERHEAT       5

`define CFG_OVERVOLT_SEL   0
`define CFG_SYNC_RECT      1
`define CFG_AUTO_RESTART   2
`define CFG_DROP_LO        4
`define CFG_DROP_HI        7
`define CFG_FILT_LO        8
`define CFG_FILT_HI        9

`define STATUS_RESET       6'h09
`define CONFIG_RESET       10'h002

`define CLK_MHZ            200
`define SYNC_DELAY_US      60
`define SYNC_DELAY_CYC     (`SYNC_DELAY_US * `CLK_MHZ)
`define OC_DELAY_MS        5
`define OC_DELAY_CYC       (`OC_DELAY_MS * 1000 * `CLK_MHZ)
`define RETRY_DELAY_S      5
`define RETRY_DELAY_CYC    (`RETRY_DELAY_S * 1000000 * `CLK_MHZ)

`endif

/* src/fault_protection_manager.v */
// Fault supervision with status and config registers over Avalon-MM
//
// Implementation choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/100ps
`include "fault_protection_defines.vh"

// What this block does
// - Undervoltage alerts and disables driver while present
// - Undervoltage sets sticky supply-low bit, write-zero clears
// - Supply-low bit set at power-up
// - Registers work in undervoltage; reset loads their reset values
// - One config bit selects overvoltage threshold
// - Overvoltage alerts, forces asynchronous rectification
// - Restore synchronous rectification 60 us after clear
// - Overvoltage sets sticky supply-high bit
// - Filtered FET drop overcurrent, selectable limit, time
// - Sense input threshold also triggers overcurrent
// - Overcurrent alerts, disables driver for 5 ms
// - Overcurrent sets sticky overcurrent bit
// - Pump-low alerts and disables driver while present
// - Pump-low bit sticky and set at power-up
// - Pump short disables for 5 s, repeats
// - Pump short sets sticky pump-short bit
// - Overheat alerts, disables, sets sticky bit
// - Auto-restart re-enables 5 s after cooling
// - No auto-restart: stay disabled until reset
// - Reset also sets supply-low and pump-low status bits, clears the rest
// - Alert output active low, open drain
module fault_protection_manager #(
    parameter OC_DELAY    = `OC_DELAY_CYC,
    parameter RETRY_DELAY = `RETRY_DELAY_CYC
) (
    input  wire        mclk,
    input  wire        resetn,
    input  wire [3:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest,
    input  wire        supply_low_ind,
    input  wire        overvolt_lo_ind,
    input  wire        overvolt_hi_ind,
    input  wire [7:0]  fet_drop_ind,
    input  wire        current_sense_input,
    input  wire        pump_low_ind,
    input  wire        pump_short_ind,
    input  wire        overheat_ind,
    output wire        overvolt_level_sel,
    output wire [3:0]  fet_drop_limit_sel,
    output reg         driver_enable,
    output reg         pump_enable,
    output reg         sync_rect_active,
    output wire        alert_out_low_o,
    output wire        alert_out_low_oe
);

    wire [5:0]  status;
    reg  [9:0]  cfg;
    reg         rd_done;
    reg  [9:0]  filt_cnt;
    reg         oc_hold;
    reg  [31:0] oc_cnt;
    reg         short_hold;
    reg  [31:0] short_cnt;
    reg  [1:0]  heat_state;
    reg  [31:0] heat_cnt;
    reg         ov_wait;
    reg  [15:0] ov_cnt;
    reg  [9:0]  filt_limit;
    wire        overvolt;
    wire        fet_trip;
    wire        oc_event;
    wire        wr_status;
    wire        wr_config;
    wire [5:0]  events;
    wire        alert;

    wire [5:0]  clear_keep;
    wire        wr_cfg_lo;
    wire        wr_cfg_hi;

    wire        heat_busy;
    wire        pump_block;
    wire        drive_block;
    wire [7:0]  state_word;

    localparam HEAT_RUN   = 2'd0;
    localparam HEAT_HOT   = 2'd1;
    localparam HEAT_WAIT  = 2'd2;
    localparam HEAT_LOCK  = 2'd3;

    localparam [15:0] SYNC_DELAY = `SYNC_DELAY_CYC;

    // Reads answer after one wait cycle; writes complete at once
    assign avs_waitrequest = avs_read & ~rd_done;
    assign wr_status = avs_write & avs_byteenable[0]
                       & (avs_address == `OFS_STATUS);
    assign wr_config = avs_write & (avs_address == `OFS_CONFIG);

    assign overvolt_level_sel = cfg[`CFG_OVERVOLT_SEL];
    assign overvolt = cfg[`CFG_OVERVOLT_SEL] ? overvolt_hi_ind
                                             : overvolt_lo_ind;
    assign fet_drop_limit_sel = cfg[`CFG_DROP_HI:`CFG_DROP_LO];
    assign fet_trip = |fet_drop_ind;

    always @* begin
        case (cfg[`CFG_FILT_HI:`CFG_FILT_LO])
            2'd0: filt_limit = 10'h0_0C8;
            2'd1: filt_limit = 10'h0_190;
            2'd2: filt_limit = 10'h0_320;
            default: filt_limit = 10'h3_FF;
        endcase
    end

    assign oc_event = (fet_trip && filt_cnt >= filt_limit)
                      || current_sense_input;

    assign events = {heat_state == HEAT_RUN && overheat_ind,
                     pump_short_ind && !short_hold,
                     pump_low_ind,
                     oc_event && !oc_hold,
                     overvolt,
                     supply_low_ind};

    assign clear_keep = wr_status ? avs_writedata[5:0] : 6'h3f;

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi = gi + 1) begin : g_flag
            sticky_flag #(
                .INIT (`STATUS_RESET >> gi)
            ) u_sticky_flag (
                .mclk   (mclk),
                .resetn (resetn),
                .set    (events[gi]),
                .keep   (clear_keep[gi]),
                .flag   (status[gi])
            );
        end
    endgenerate

    // Config lanes honoured one byte at a time
    assign wr_cfg_lo = wr_config & avs_byteenable[0];
    assign wr_cfg_hi = wr_config & avs_byteenable[1];

    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cfg     <= `CONFIG_RESET;
            rd_done <= 1'b0;
        end else begin
            rd_done <= avs_read & ~rd_done;
            if (wr_cfg_lo)
                cfg[7:0] <= avs_writedata[7:0];
            if (wr_cfg_hi)
                cfg[9:8] <= avs_writedata[9:8];
        end
    end

    assign state_word = {heat_state,
                         short_hold,
                         oc_hold,
                         ov_wait,
                         sync_rect_active,
                         pump_enable,
                         driver_enable};

    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !rd_done) begin
            case (avs_address)
                `OFS_STATUS: avs_readdata <= {26'h0, status};
                `OFS_CONFIG: avs_readdata <= {22'h0, cfg};
                `OFS_STATE:  avs_readdata <= {24'h0, state_word};
                default:     avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // drop persistence filter
    // Drop only counts across a driven FET
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            filt_cnt <= 10'h000;
        end else if (!fet_trip || !driver_enable) begin
            filt_cnt <= 10'h000;
        end else if (filt_cnt < filt_limit) begin
            filt_cnt <= filt_cnt + 10'h001;
        end
    end

    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            oc_hold <= 1'b0;
            oc_cnt  <= 32'h0000_0000;
        end else if (oc_hold) begin
            if (oc_cnt >= OC_DELAY - 1) begin
                oc_hold <= 1'b0;
                oc_cnt  <= 32'h0000_0000;
            end else begin
                oc_cnt <= oc_cnt + 32'h0000_0001;
            end
        end else if (oc_event) begin
            oc_hold <= 1'b1;
        end
    end

    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            short_hold <= 1'b0;
            short_cnt  <= 32'h0000_0000;
        end else if (short_hold) begin
            if (short_cnt >= RETRY_DELAY - 1) begin
                short_hold <= 1'b0;
                short_cnt  <= 32'h0000_0000;
            end else begin
                short_cnt <= short_cnt + 32'h0000_0001;
            end
        end else if (pump_short_ind) begin
            short_hold <= 1'b1;
        end
    end

    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            heat_state <= HEAT_RUN;
            heat_cnt   <= 32'h0000_0000;
        end else begin
            case (heat_state)
                HEAT_RUN: begin
                    heat_cnt <= 32'h0000_0000;
                    if (overheat_ind)
                        heat_state <= HEAT_HOT;
                end
                HEAT_HOT: begin
                    heat_cnt <= 32'h0000_0000;
                    if (!overheat_ind)
                        heat_state <= cfg[`CFG_AUTO_RESTART]
                                      ? HEAT_WAIT : HEAT_LOCK;
                end
                HEAT_WAIT: begin
                    if (overheat_ind) begin
                        heat_state <= HEAT_HOT;
                    end else if (heat_cnt >= RETRY_DELAY - 1) begin
                        heat_state <= HEAT_RUN;
                    end else begin
                        heat_cnt <= heat_cnt + 32'h0000_0001;
                    end
                end
                HEAT_LOCK:
                    heat_state <= HEAT_LOCK;
                default:
                    heat_state <= HEAT_RUN;
            endcase
        end
    end

    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ov_wait          <= 1'b0;
            ov_cnt           <= 16'h0000;
            sync_rect_active <= 1'b0;
        end else if (!cfg[`CFG_SYNC_RECT]) begin
            ov_wait          <= 1'b0;
            ov_cnt           <= 16'h0000;
            sync_rect_active <= 1'b0;
        end else if (overvolt) begin
            ov_wait          <= 1'b1;
            ov_cnt           <= 16'h0000;
            sync_rect_active <= 1'b0;
        end else if (ov_wait) begin
            if (ov_cnt >= SYNC_DELAY - 16'h0001) begin
                ov_wait          <= 1'b0;
                sync_rect_active <= 1'b1;
            end else begin
                ov_cnt <= ov_cnt + 16'h0001;
            end
        end else begin
            sync_rect_active <= 1'b1;
        end
    end

    // undervoltage and pump-low gate the driver
    assign heat_busy   = heat_state != HEAT_RUN;
    assign pump_block  = short_hold || pump_short_ind;
    assign drive_block = supply_low_ind || oc_hold || oc_event
                         || pump_low_ind || pump_block
                         || overheat_ind || heat_busy;
    // Overvoltage alerts and forces asynchronous rectification; the driver keeps running
    assign alert = drive_block || overvolt;

    // Registered, so enables lag the fault by one edge
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            driver_enable <= 1'b0;
            pump_enable   <= 1'b0;
        end else begin
            driver_enable <= !drive_block;
            pump_enable   <= !pump_block;
        end
    end

    assign alert_out_low_o  = 1'b0;
    assign alert_out_low_oe = alert;

endmodule

// One status bit: event sets, write-zero clears, set wins
module sticky_flag #(
    parameter INIT = 1'b0
) (
    input  wire mclk,
    input  wire resetn,
    input  wire set,
    input  wire keep,
    output reg  flag
);

    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            flag <= INIT[0];
        end else begin
            flag <= (flag & keep) | set;
        end
    end

endmodule

/* bench/fault_comparators.sv */
// Fault comparator and pre-driver stand-in at the block's far side
`timescale 1ns/100ps
module fault_comparators (
    input  wire       mclk,
    input  wire [7:0] fault_cmd,
    input  wire       driver_enable,
    input  wire       alert_out_low_o,
    input  wire       alert_out_low_oe,
    output reg  [6:0] ind = 7'h00,
    output reg  [7:0] fet_drop_ind = 8'h00,
    output wire       alert_pin
);
    // Drop only measurable across a driven FET
    always @(posedge mclk) begin
        ind          <= fault_cmd[6:0];
        fet_drop_ind <= driver_enable ? {4'h0, fault_cmd[7], 3'h0} : 8'h00;
    end
    assign alert_pin = alert_out_low_oe ? alert_out_low_o : 1'b1;
endmodule

/* bench/fault_protection_manager_sva.sv */
// Port-level checks of the fault supervision block
`timescale 1ns/100ps
module fault_protection_manager_sva #(
    parameter OC_DELAY    = 50,
    parameter RETRY_DELAY = 100
) (
    input wire       mclk,
    input wire       resetn,
    input wire       supply_low_ind,
    input wire       overvolt_lo_ind,
    input wire       overvolt_hi_ind,
    input wire [7:0] fet_drop_ind,
    input wire       current_sense_input,
    input wire       pump_low_ind,
    input wire       pump_short_ind,
    input wire       overheat_ind,
    input wire       overvolt_level_sel,
    input wire       driver_enable,
    input wire       pump_enable,
    input wire       sync_rect_active,
    input wire       alert_out_low_o,
    input wire       alert_out_low_oe
);
    wire ov = overvolt_level_sel ? overvolt_hi_ind : overvolt_lo_ind;
    wire fault_any = supply_low_ind | ov | current_sense_input
        | pump_low_ind | pump_short_ind | overheat_ind | (|fet_drop_ind);
    default clocking dc @(posedge mclk); endclocking
    default disable iff (!resetn);
    a_undervolt_stop: assert property (
        supply_low_ind |-> alert_out_low_oe ##1 !driver_enable)
        else $error("undervoltage left driver on");
    a_pumplow_stop: assert property (
        pump_low_ind |-> alert_out_low_oe ##1 !driver_enable)
        else $error("pump low left driver on");
    a_overvolt_async: assert property (
        ov |-> alert_out_low_oe ##1 !sync_rect_active)
        else $error("overvoltage kept sync rectification");
    a_sync_waits: assert property (
        $fell(ov) |-> !sync_rect_active [*8])
        else $error("sync rectification back too soon");
    a_overheat_stop: assert property (
        overheat_ind |=> !driver_enable && alert_out_low_oe)
        else $error("overheat left driver on");
    a_short_stop: assert property (
        pump_short_ind |=> !pump_enable && !driver_enable && alert_out_low_oe)
        else $error("pump short left pump on");
    a_sense_trip: assert property (
        current_sense_input |=> (!driver_enable && alert_out_low_oe) [*2])
        else $error("sense overcurrent not held");
    a_pin_low: assert property (
        alert_out_low_oe |-> alert_out_low_o == 1'b0)
        else $error("alert pin not driven low");
    a_quiet_pin: assert property (
        driver_enable && !fault_any |-> !alert_out_low_oe)
        else $error("alert with no fault present");
endmodule
bind fault_protection_manager fault_protection_manager_sva #(
    .OC_DELAY(OC_DELAY), .RETRY_DELAY(RETRY_DELAY)
) u_fault_protection_manager_sva (
    .mclk(mclk), .resetn(resetn), .supply_low_ind(supply_low_ind),
    .overvolt_lo_ind(overvolt_lo_ind), .overvolt_hi_ind(overvolt_hi_ind),
    .fet_drop_ind(fet_drop_ind), .current_sense_input(current_sense_input),
    .pump_low_ind(pump_low_ind), .pump_short_ind(pump_short_ind),
    .overheat_ind(overheat_ind), .overvolt_level_sel(overvolt_level_sel),
    .driver_enable(driver_enable), .pump_enable(pump_enable),
    .sync_rect_active(sync_rect_active), .alert_out_low_o(alert_out_low_o),
    .alert_out_low_oe(alert_out_low_oe));

/* bench/fault_protection_manager_bench.sv */
// Self-checking bench for the fault supervision block
`timescale 1ns/100ps
module fault_protection_manager_bench;
    localparam int OC = 50;
    localparam int RT = 100;
    reg         mclk = 1'b0;
    reg         resetn = 1'b0;
    reg  [3:0]  avs_address = 4'h0;
    reg         avs_read = 1'b0;
    reg         avs_write = 1'b0;
    reg  [31:0] avs_writedata = 32'h0000_0000;
    wire [31:0] avs_readdata;
    wire        avs_waitrequest;
    reg  [7:0]  fault_cmd = 8'h00;
    wire [6:0]  ind;
    wire [7:0]  fet_drop_ind;
    wire [3:0]  limit;
    wire        ov_sel, driver_enable, pump_enable, sync_rect_active;
    wire        al_o, al_oe, alert_pin;
    reg  [31:0] rd;
    integer     num_errors = 0;
    integer     total_checks = 0;
    integer     n;
    always #2.5 mclk = ~mclk;
    fault_protection_manager #(.OC_DELAY(OC), .RETRY_DELAY(RT))
    u_fault_protection_manager (.mclk(mclk), .resetn(resetn),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .supply_low_ind(ind[0]),
        .overvolt_lo_ind(ind[1]), .overvolt_hi_ind(ind[2]),
        .fet_drop_ind(fet_drop_ind), .current_sense_input(ind[3]),
        .pump_low_ind(ind[4]), .pump_short_ind(ind[5]),
        .overheat_ind(ind[6]), .overvolt_level_sel(ov_sel),
        .fet_drop_limit_sel(limit), .driver_enable(driver_enable),
        .pump_enable(pump_enable), .sync_rect_active(sync_rect_active),
        .alert_out_low_o(al_o), .alert_out_low_oe(al_oe));
    fault_comparators u_fault_comparators (.mclk(mclk),
        .fault_cmd(fault_cmd), .driver_enable(driver_enable),
        .alert_out_low_o(al_o), .alert_out_low_oe(al_oe), .ind(ind),
        .fet_drop_ind(fet_drop_ind), .alert_pin(alert_pin));
    task chk(input string nm, input [31:0] e, input [31:0] g);
        total_checks = total_checks + 1;
        if (g !== e) begin
            num_errors = num_errors + 1;
            $display("Error %0s expected %h seen %h", nm, e, g);
        end
    endtask
    // Request held until waitrequest seen low at an edge
    task acc(input w, input [3:0] a, input [31:0] d);
        @(posedge mclk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= w;
        avs_read      <= !w;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0)
            @(posedge mclk);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask
    task rdc(input [3:0] a, input [31:0] e, input string nm);
        acc(1'b0, a, 32'h0000_0000);
        chk(nm, e, rd);
    endtask
    task cyc(input integer k);
        repeat (k) @(posedge mclk);
        @(negedge mclk);
    endtask
    task fs(input [7:0] v);
        @(posedge mclk);
        fault_cmd <= v;
    endtask
    // Pulse a fault, count cycles until the driver is back
    task trip(input [7:0] v);
        fs(v);
        fs(8'h00);
        cyc(2);
        chk("driver", 0, driver_enable);
        chk("alert", 0, alert_pin);
        n = 0;
        while (driver_enable !== 1'b1 && n < 30000) begin
            @(negedge mclk);
            n = n + 1;
        end
    endtask
    task give_verdict;
        $display("Checks %0d, errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        rdc(4'h0, 32'h0000_0009, "status");
        rdc(4'h4, 32'h0000_0002, "config");
        acc(1'b1, 4'hc, 32'hffff_ffff);
        rdc(4'hc, 32'h0000_0000, "unmapped");
        acc(1'b1, 4'h0, 32'h0000_0000);
        rdc(4'h0, 32'h0000_0000, "status");
        for (int i = 0; i < 2; i++) begin
            fs(i ? 8'h10 : 8'h01);
            cyc(3);
            chk("alert", 0, alert_pin);
            chk("driver", 0, driver_enable);
            rdc(4'h4, 32'h0000_0002, "config");
            fs(8'h00);
            cyc(3);
            chk("alert", 1, alert_pin);
            chk("driver", 1, driver_enable);
            rdc(4'h0, i ? 32'h8 : 32'h1, "sticky");
            acc(1'b1, 4'h0, 32'h0000_0000);
        end
        fs(8'h04);
        cyc(3);
        chk("alert", 1, alert_pin);
        acc(1'b1, 4'h4, 32'h0000_0053);
        cyc(2);
        chk("limit", 5, limit);
        chk("alert", 0, alert_pin);
        chk("sync", 0, sync_rect_active);
        fs(8'h00);
        cyc(2);
        chk("alert", 1, alert_pin);
        n = 0;
        while (sync_rect_active !== 1'b1 && n < 13000) begin
            @(negedge mclk);
            n = n + 1;
        end
        chk("sync wait", 1, n > 60 * 200 - 20 && n < 60 * 200 + 5);
        rdc(4'h0, 32'h0000_0002, "status");
        acc(1'b1, 4'h0, 32'h0000_0000);
        trip(8'h08);
        chk("oc hold", 1, n > OC - 8 && n < OC + 4);
        rdc(4'h0, 32'h0000_0004, "status");
        acc(1'b1, 4'h0, 32'h0000_0000);
        fs(8'h80);
        cyc(150);
        fs(8'h00);
        rdc(4'h0, 32'h0000_0000, "short drop");
        fs(8'h80);
        cyc(300);
        fs(8'h00);
        rdc(4'h0, 32'h0000_0004, "long drop");
        acc(1'b1, 4'h0, 32'h0000_0000);
        cyc(OC + 10);
        trip(8'h20);
        chk("retry", 1, n > RT - 8 && n < RT + 4);
        rdc(4'h0, 32'h0000_0010, "status");
        acc(1'b1, 4'h0, 32'h0000_0000);
        acc(1'b1, 4'h4, 32'h0000_0006);
        trip(8'h40);
        chk("restart", 1, n > RT - 8 && n < RT + 4);
        rdc(4'h0, 32'h0000_0020, "status");
        acc(1'b1, 4'h4, 32'h0000_0002);
        fs(8'h40);
        fs(8'h00);
        cyc(3 * RT);
        chk("locked", 0, driver_enable);
        @(posedge mclk);
        resetn <= 1'b0;
        cyc(3);
        @(posedge mclk);
        resetn <= 1'b1;
        cyc(2);
        chk("driver", 1, driver_enable);
        rdc(4'h0, 32'h0000_0009, "status");
        give_verdict;
    end
    // Whole run is near 13200 cycles
    initial begin
        #250000;
        num_errors = num_errors + 1;
        give_verdict;
    end
endmodule
